// ---- hw/lsp_params.svh ----
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH
// register offsets
`define LSP_REG_STR_EN0    8'h00
`define LSP_REG_FAULT0     8'h06
`define LSP_FAULT_REGS     5
`define LSP_REG_OPT_CTRL   8'h12
`define LSP_REG_OPT_DAC1   8'h13
`define LSP_REG_MUL        8'h23
`define LSP_REG_PWM_CTRL   8'h2D
`define LSP_REG_PHASE_CTRL 8'h2E
`define LSP_REG_CURRENT    8'h31
`define LSP_REG_INTENSITY  8'h32
`define LSP_REG_STR_SET    8'h40
`define LSP_REG_ON_TIME    8'h60
`define LSP_REG_DELAY      8'h80
`define LSP_REG_COUNT      8'hA0
// field positions
`define LSP_PWM_ON_BIT     0
`define LSP_PWM_DIRECT_BIT 1
`define LSP_PWM_GATE_BIT   2
`define LSP_PWM_SCALE_BIT  3
`define LSP_PWM_SRC_BIT    4
`define LSP_SPREAD_BIT     0
`define LSP_OPT_EN_BIT     0
`define LSP_OPT_PERIOD_BIT 1
`define LSP_FLT_RATE_BIT   3
// reset values
`define LSP_CFG_RESET      8'h00
// timing
`define LSP_CLK_NS         100
`define LSP_CC_MIN_NS      400
`define LSP_CC_MIN_CYC     ((`LSP_CC_MIN_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
`define LSP_STEP_US        100
`define LSP_STEP_CYC       ((`LSP_STEP_US * 1000) / `LSP_CLK_NS)
`define LSP_INT_FRAME_US   5000
`define LSP_INT_FRAME_CYC  ((`LSP_INT_FRAME_US * 1000) / `LSP_CLK_NS)
`define LSP_REOPT_MS       1000
`define LSP_REOPT_CYC      ((`LSP_REOPT_MS * 1000000) / `LSP_CLK_NS)
`define LSP_DIRECT_MAX_MS  100
`define LSP_DIRECT_MAX_CYC ((`LSP_DIRECT_MAX_MS * 1000000) / `LSP_CLK_NS)
`endif

// ---- hw/lsp_pkg.sv ----
`default_nettype none
package lsp_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] dev;
    logic [7:0] addr;
    logic [7:0] data;
  } lsp_req_t;
  typedef enum {BOOT_LOAD, BOOT_RUN} lsp_boot_t;
  typedef enum {OPT_OFF, OPT_WAIT, OPT_STEP, OPT_HOLD} lsp_opt_t;
endpackage : lsp_pkg
`default_nettype wire

// ---- hw/lsp_core.sv ----
`include "lsp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module lsp_core #(
  parameter int INT_FRAME_CYC  = `LSP_INT_FRAME_CYC,
  parameter int REOPT_CYC      = `LSP_REOPT_CYC,
  parameter int DIRECT_MAX_CYC = `LSP_DIRECT_MAX_CYC,
  parameter int STRINGS        = 16
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // device control
  input  wire logic             enable_i,
  input  wire logic [2:0]       dev_addr_i,
  // decoded serial register access
  input  wire lsp_pkg::lsp_req_t req_i,
  output logic      [7:0]       rd_data_o,
  output logic                  rd_valid_o,
  // nonvolatile defaults, read combinationally
  output logic      [7:0]       nvm_addr_o,
  input  wire logic [7:0]       nvm_data_i,
  // timing inputs
  input  wire logic             frame_reference_in_i,
  input  wire logic             count_clock_in_i,
  input  wire logic             pwm_in_i,
  // string and supply feedback
  input  wire logic [15:0]      string_in_reg_i,
  input  wire logic [39:0]      fault_evt_i,
  // drive outputs
  output logic      [15:0]      string_drive_o,
  output logic      [7:0]       string_current_level_o,
  output logic      [23:0]      optimizer_current_out_o,
  output logic                  optimizer_on_o
);
  localparam int PW = 20;
  localparam int RW = 24;
  localparam logic [PW-1:0] DMAX = PW'(DIRECT_MAX_CYC);

  initial begin
    if (STRINGS != 16 || DIRECT_MAX_CYC >= (1 << PW) || DIRECT_MAX_CYC < 2 ||
        REOPT_CYC >= (1 << RW) || REOPT_CYC < 1 || INT_FRAME_CYC >= (1 << PW) || INT_FRAME_CYC < 2)
      $error("lsp_core: unsupported parameter values");
  end

  function automatic logic [11:0] scale_fn(input logic [11:0] on, input logic [7:0] lvl);
    logic [20:0] p;
    p = 21'(on) * 21'({1'b0, lvl} + 9'h001);
    return p[19:8];
  endfunction : scale_fn

  logic [7:0]        cfg_r [0:`LSP_REG_COUNT-1];
  logic [7:0]        fault_r [0:`LSP_FAULT_REGS-1];
  lsp_pkg::lsp_boot_t boot_st;
  logic [7:0]        boot_addr_r;
  logic              en_prev_r;
  logic              en_rise;
  logic              run;
  logic              rate_flt;

  assign en_rise = enable_i && !en_prev_r;
  assign run     = enable_i && boot_st == lsp_pkg::BOOT_RUN;

  always_ff @(posedge ref_clk_i) begin
    // reset to the idle-high level so a strapped-high enable gives no false rise
    if (reset_i) en_prev_r <= 1'b1;
    else en_prev_r <= enable_i;
  end

  // boot loader: reset and every enable rise walk the whole map
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      boot_st     <= lsp_pkg::BOOT_LOAD;
      boot_addr_r <= 8'h00;
    end else if (en_rise) begin
      boot_st     <= lsp_pkg::BOOT_LOAD;
      boot_addr_r <= 8'h00;
    end else begin
      case (boot_st)
        lsp_pkg::BOOT_LOAD: begin
          boot_addr_r <= boot_addr_r + 8'h01;
          if (boot_addr_r == 8'(`LSP_REG_COUNT - 1)) boot_st <= lsp_pkg::BOOT_RUN;
        end
        lsp_pkg::BOOT_RUN: boot_addr_r <= 8'h00;
        default: boot_st <= lsp_pkg::BOOT_LOAD;
      endcase
    end
  end
  assign nvm_addr_o = boot_addr_r;

  logic host_hit;
  assign host_hit = run && req_i.dev == dev_addr_i;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `LSP_REG_COUNT; i++) cfg_r[i] <= `LSP_CFG_RESET;
    end else if (boot_st == lsp_pkg::BOOT_LOAD) begin
      cfg_r[boot_addr_r] <= nvm_data_i;
    end else if (host_hit && req_i.wr && req_i.addr < 8'(`LSP_REG_COUNT)) begin
      cfg_r[req_i.addr] <= req_i.data;
    end
  end

  // hardware set wins over the enable-rise clear
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < `LSP_FAULT_REGS; i++) begin
      if (reset_i) fault_r[i] <= 8'h00;
      else if (en_rise) fault_r[i] <= fault_evt_i[i*8 +: 8] |
                                      ((i == 0 && rate_flt) ? 8'(1 << `LSP_FLT_RATE_BIT) : 8'h00);
      else fault_r[i] <= fault_r[i] | fault_evt_i[i*8 +: 8] |
                         ((i == 0 && rate_flt) ? 8'(1 << `LSP_FLT_RATE_BIT) : 8'h00);
    end
  end

  // field decode
  logic [7:0]  pwm_ctl, mul;
  logic        pwm_on, direct, gate, spread, src_int;
  logic [15:0] str_en;
  assign pwm_ctl = cfg_r[`LSP_REG_PWM_CTRL];
  assign pwm_on  = pwm_ctl[`LSP_PWM_ON_BIT];
  assign direct  = pwm_on && pwm_ctl[`LSP_PWM_DIRECT_BIT];
  assign gate    = pwm_ctl[`LSP_PWM_GATE_BIT];
  assign src_int = pwm_ctl[`LSP_PWM_SRC_BIT];
  assign spread  = cfg_r[`LSP_REG_PHASE_CTRL][`LSP_SPREAD_BIT];
  assign mul     = {3'b000, cfg_r[`LSP_REG_MUL][4:0]};
  assign str_en  = {cfg_r[`LSP_REG_STR_EN0 + 1], cfg_r[`LSP_REG_STR_EN0]};
  assign string_current_level_o = cfg_r[`LSP_REG_CURRENT];

  // frame reference multiplier: spread mul extra frame starts over the measured period
  logic          ref_prev_r, ref_edge, mult_pulse, int_pulse, frame_pulse;
  logic [PW-1:0] ref_cnt_r, ref_per_r, acc_r, acc_nxt, int_cnt_r;
  logic [4:0]    sub_cnt_r;
  assign ref_edge = frame_reference_in_i && !ref_prev_r;
  assign acc_nxt  = acc_r + PW'(mul) + PW'(1);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_prev_r <= 1'b0;
      ref_cnt_r  <= '0;
      ref_per_r  <= '0;
      acc_r      <= '0;
      sub_cnt_r  <= 5'h00;
      mult_pulse <= 1'b0;
    end else begin
      ref_prev_r <= frame_reference_in_i;
      mult_pulse <= 1'b0;
      if (ref_edge) begin
        ref_per_r  <= ref_cnt_r + PW'(1);
        ref_cnt_r  <= '0;
        acc_r      <= '0;
        sub_cnt_r  <= 5'h00;
        mult_pulse <= 1'b1;
      end else begin
        if (ref_cnt_r != DMAX) ref_cnt_r <= ref_cnt_r + PW'(1);
        if (ref_per_r != '0 && acc_nxt >= ref_per_r && sub_cnt_r < mul[4:0]) begin
          acc_r      <= acc_nxt - ref_per_r;
          sub_cnt_r  <= sub_cnt_r + 5'h01;
          mult_pulse <= 1'b1;
        end else if (acc_nxt < ref_per_r) begin
          acc_r <= acc_nxt;
        end
      end
    end
  end

  // standalone frame timer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || int_cnt_r == PW'(INT_FRAME_CYC - 1)) int_cnt_r <= '0;
    else int_cnt_r <= int_cnt_r + PW'(1);
  end
  assign int_pulse   = int_cnt_r == '0;
  assign frame_pulse = src_int ? int_pulse : mult_pulse;

  // count clock edge, frame-relative count and rate check
  logic          cc_prev_r, cc_edge;
  logic [11:0]   gs_cnt_r;
  logic [PW-1:0] cc_gap_r;
  assign cc_edge = count_clock_in_i && !cc_prev_r;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cc_prev_r <= 1'b0;
      gs_cnt_r  <= 12'h000;
      cc_gap_r  <= DMAX;
      rate_flt  <= 1'b0;
    end else begin
      cc_prev_r <= count_clock_in_i;
      rate_flt  <= cc_edge && run && !direct &&
                   cc_gap_r < PW'(`LSP_CC_MIN_CYC) * (PW'(mul) + PW'(1));
      if (cc_edge) cc_gap_r <= PW'(1);
      else if (cc_gap_r != DMAX) cc_gap_r <= cc_gap_r + PW'(1);
      if (frame_pulse) gs_cnt_r <= 12'h000;
      else if (cc_edge && gs_cnt_r != 12'hFFF) gs_cnt_r <= gs_cnt_r + 12'h001;
    end
  end

  // direct drive period and high-time measurement
  logic          pwm_prev_r, pwm_edge, stale;
  logic [PW-1:0] t_r, hi_cnt_r, per_r, high_r;
  assign pwm_edge = pwm_in_i && !pwm_prev_r;
  assign stale    = t_r == DMAX || per_r == '0;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pwm_prev_r <= 1'b0;
      t_r        <= DMAX;
      hi_cnt_r   <= '0;
      per_r      <= '0;
      high_r     <= '0;
    end else begin
      pwm_prev_r <= pwm_in_i;
      if (pwm_edge) begin
        per_r    <= t_r + PW'(1);
        high_r   <= hi_cnt_r;
        t_r      <= '0;
        hi_cnt_r <= PW'(1);
      end else begin
        if (t_r != DMAX) t_r <= t_r + PW'(1);
        if (pwm_in_i && hi_cnt_r != DMAX) hi_cnt_r <= hi_cnt_r + PW'(1);
      end
    end
  end

  // per-string waveform
  logic [15:0] int_on, dir_on, drive_nxt;
  always_comb begin
    logic [11:0] on_t, dly, son;
    logic [PW:0] st, en_t;
    on_t   = '0;
    dly    = '0;
    son    = '0;
    st     = '0;
    en_t   = '0;
    int_on = '0;
    dir_on = '0;
    for (int n = 0; n < 16; n++) begin
      on_t = {cfg_r[`LSP_REG_ON_TIME + 2*n + 1][3:0], cfg_r[`LSP_REG_ON_TIME + 2*n]};
      dly  = {cfg_r[`LSP_REG_DELAY + 2*n + 1][3:0], cfg_r[`LSP_REG_DELAY + 2*n]};
      son  = pwm_ctl[`LSP_PWM_SCALE_BIT] ? scale_fn(on_t, cfg_r[`LSP_REG_INTENSITY]) : on_t;
      int_on[n] = gs_cnt_r >= dly && 13'(gs_cnt_r) < 13'(dly) + 13'(son);
      st   = (PW+1)'(PW'(n) * (per_r >> 4));
      en_t = st + (PW+1)'(high_r);
      dir_on[n] = ((PW+1)'(t_r) >= st && (PW+1)'(t_r) < en_t) ||
                  (en_t > (PW+1)'(per_r) && (PW+1)'(t_r) < en_t - (PW+1)'(per_r));
    end
    if (!run || !pwm_on) drive_nxt = '0;
    else if (direct) drive_nxt = (spread && !stale) ? dir_on : {16{pwm_in_i}};
    else if (gate) drive_nxt = int_on & {16{pwm_in_i}};
    else drive_nxt = int_on;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) string_drive_o <= '0;
    else string_drive_o <= drive_nxt & str_en;
  end

  // supply optimizer: raise injected current one step at a time while regulation holds
  lsp_pkg::lsp_opt_t opt_st;
  logic [2:0][7:0]   dac_r;
  logic [2:0]        done_r, ok, done_nxt;
  logic [RW-1:0]     wait_r;
  logic              opt_en, opt_per;
  assign opt_en  = cfg_r[`LSP_REG_OPT_CTRL][`LSP_OPT_EN_BIT];
  assign opt_per = cfg_r[`LSP_REG_OPT_CTRL][`LSP_OPT_PERIOD_BIT];
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      ok[k] = 1'b1;
      for (int n = 0; n < 16; n++)
        if (str_en[n] && cfg_r[`LSP_REG_STR_SET + n][1:0] == 2'(k + 1) && !string_in_reg_i[n])
          ok[k] = 1'b0;
      done_nxt[k] = done_r[k] || !ok[k] || dac_r[k] == 8'hFF;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !run || !opt_en) begin
      opt_st <= lsp_pkg::OPT_OFF;
      dac_r  <= '0;
      done_r <= 3'b000;
      wait_r <= '0;
    end else begin
      case (opt_st)
        lsp_pkg::OPT_OFF: opt_st <= lsp_pkg::OPT_WAIT;
        lsp_pkg::OPT_WAIT: begin
          wait_r <= wait_r + RW'(1);
          if (wait_r == RW'(`LSP_STEP_CYC - 1)) begin
            wait_r <= '0;
            opt_st <= lsp_pkg::OPT_STEP;
          end
        end
        lsp_pkg::OPT_STEP: begin
          for (int k = 0; k < 3; k++) begin
            if (!done_r[k] && ok[k] && dac_r[k] != 8'hFF) dac_r[k] <= dac_r[k] + 8'h01;
            else if (!done_r[k] && !ok[k] && dac_r[k] != 8'h00) dac_r[k] <= dac_r[k] - 8'h01;
          end
          done_r <= done_nxt;
          opt_st <= (&done_nxt) ? lsp_pkg::OPT_HOLD : lsp_pkg::OPT_WAIT;
        end
        lsp_pkg::OPT_HOLD: begin
          if (opt_per) begin
            wait_r <= wait_r + RW'(1);
            if (wait_r == RW'(REOPT_CYC - 1)) begin
              wait_r <= '0;
              done_r <= 3'b000;
              opt_st <= lsp_pkg::OPT_WAIT;
            end
          end
        end
        default: opt_st <= lsp_pkg::OPT_OFF;
      endcase
    end
  end
  assign optimizer_current_out_o = dac_r;
  assign optimizer_on_o          = opt_st != lsp_pkg::OPT_OFF;

  // register read: status locations show live state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= host_hit && req_i.rd;
      if (req_i.addr >= `LSP_REG_FAULT0 && req_i.addr < `LSP_REG_FAULT0 + 8'(`LSP_FAULT_REGS))
        rd_data_o <= fault_r[3'(req_i.addr - `LSP_REG_FAULT0)];
      else if (req_i.addr >= `LSP_REG_OPT_DAC1 && req_i.addr < `LSP_REG_OPT_DAC1 + 8'h03)
        rd_data_o <= dac_r[2'(req_i.addr - `LSP_REG_OPT_DAC1)];
      else if (req_i.addr < 8'(`LSP_REG_COUNT)) rd_data_o <= cfg_r[req_i.addr];
      else rd_data_o <= 8'h00;
    end
  end

  a_en_low_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !enable_i |=> string_drive_o == 16'h0000 && !optimizer_on_o) else $error("strings or optimizer on while disabled");
  a_en_rise_boot: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    en_rise |=> boot_st == lsp_pkg::BOOT_LOAD && boot_addr_r == 8'h00) else $error("no reload on enable");
  a_boot_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    boot_st == lsp_pkg::BOOT_LOAD |=> cfg_r[$past(boot_addr_r)] == $past(nvm_data_i)) else $error("boot copy lost");
  a_fault_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    en_rise && fault_evt_i == 40'h0 |=> fault_r[1] == 8'h00 && fault_r[4] == 8'h00) else $error("faults not cleared");
  a_direct_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    run && direct && !spread |=> string_drive_o == ($past(str_en) & {16{$past(pwm_in_i)}})) else $error("direct drive wrong");
  a_gate_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    run && pwm_on && !direct && gate && !pwm_in_i |=> string_drive_o == 16'h0000) else $error("gate ignored");
  a_frame_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    frame_pulse ##1 !frame_pulse && !cc_edge |=> gs_cnt_r == 12'h000) else $error("frame count not restarted");
  a_opt_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    opt_st == lsp_pkg::OPT_WAIT && $past(opt_st) == lsp_pkg::OPT_WAIT |-> $stable(dac_r)) else $error("current moved between steps");
  a_spread_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    run && direct && spread && !stale && t_r == '0 && high_r != '0 |=> string_drive_o[0] == $past(str_en[0]))
    else $error("string 0 late in spread mode");
  c_boot_done: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(boot_st == lsp_pkg::BOOT_RUN));
  c_spread: cover property (@(posedge ref_clk_i) disable iff (reset_i) run && direct && spread && string_drive_o[15]);
  c_gated: cover property (@(posedge ref_clk_i) disable iff (reset_i) run && gate && !direct && |string_drive_o);
  c_opt_hold: cover property (@(posedge ref_clk_i) disable iff (reset_i) opt_st == lsp_pkg::OPT_HOLD && dac_r[0] != 8'h00);
endmodule : lsp_core
`default_nettype wire

// ---- tb/lsp_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsp_partner #(
  parameter int CC_HALF  = 4,
  parameter int REF_HALF = 200
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // default store
  input  wire logic [7:0] nvm_addr_i,
  output logic      [7:0] nvm_data_o,
  // video timing
  output logic            frame_reference_in_o,
  output logic            count_clock_in_o
);
  int cc_cnt;
  int ref_cnt;

  // defaults as the host left them: all strings on, all fed by output 1
  always_comb begin
    case (nvm_addr_i)
      8'h00, 8'h01: nvm_data_o = 8'hFF;
      8'h31:        nvm_data_o = 8'h5A;
      default:      nvm_data_o = (nvm_addr_i[7:5] == 3'h2) ? 8'h01 : 8'h00;
    endcase
  end

  // count clock period 8 cycles keeps the rate limit with multiplier 0
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || cc_cnt == 2 * CC_HALF - 1) cc_cnt <= 0;
    else cc_cnt <= cc_cnt + 1;
    count_clock_in_o <= !reset_i && cc_cnt < CC_HALF;
  end

  // frame reference runs free, as a video sync does
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || ref_cnt == 2 * REF_HALF - 1) ref_cnt <= 0;
    else ref_cnt <= ref_cnt + 1;
    frame_reference_in_o <= !reset_i && ref_cnt < REF_HALF;
  end
endmodule : lsp_partner
`default_nettype wire

// ---- tb/lsp_core_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsp_core_tb_top;
  logic              ref_clk_i       = 1'b0;
  logic              reset_i         = 1'b1;
  logic              enable_i        = 1'b1;
  logic              pwm_in_i        = 1'b0;
  logic [2:0]        dev_addr_i      = 3'h5;
  logic [15:0]       string_in_reg_i = 16'hFFFF;
  logic [39:0]       fault_evt_i     = 40'h0;
  lsp_pkg::lsp_req_t req_i           = '0;
  logic [7:0]        rd_data_o;
  logic [7:0]        nvm_addr_o;
  logic [7:0]        nvm_data_i;
  logic [7:0]        string_current_level_o;
  logic              rd_valid_o;
  logic              frame_ref;
  logic              count_clk;
  logic              optimizer_on_o;
  logic [15:0]       string_drive_o;
  logic [23:0]       optimizer_current_out_o;
  int                err_count = 0;
  int                n_checks  = 0;
  int                regs [256];

  lsp_core #(.INT_FRAME_CYC(64), .REOPT_CYC(3000), .DIRECT_MAX_CYC(4096)) lsp_core_i (
    .ref_clk_i, .reset_i, .enable_i, .dev_addr_i, .req_i, .rd_data_o, .rd_valid_o,
    .nvm_addr_o, .nvm_data_i, .frame_reference_in_i(frame_ref), .count_clock_in_i(count_clk),
    .pwm_in_i, .string_in_reg_i, .fault_evt_i, .string_drive_o, .string_current_level_o,
    .optimizer_current_out_o, .optimizer_on_o
  );

  lsp_partner lsp_partner_i (
    .ref_clk_i, .reset_i, .nvm_addr_i(nvm_addr_o), .nvm_data_o(nvm_data_i),
    .frame_reference_in_o(frame_ref), .count_clock_in_o(count_clk)
  );

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  function automatic void init_model();
    foreach (regs[i]) regs[i] = (i >= 8'h40 && i < 8'h60) ? 1 : 0;
    regs[8'h00] = 8'hFF;
    regs[8'h01] = 8'hFF;
    regs[8'h31] = 8'h5A;
  endfunction : init_model

  function automatic logic [15:0] spread_exp(input int t);
    logic [15:0] e;
    for (int n = 0; n < 16; n++) e[n] = ((t - n * 10 + 160) % 160) < 80;
    return e;
  endfunction : spread_exp

  // request held for one cycle, answer awaited a bounded time
  task automatic acc(input logic w, input logic [2:0] dev, input logic [7:0] a, input logic [7:0] d,
                     output logic ok, output logic [7:0] q);
    @(posedge ref_clk_i);
    req_i <= '{wr: w, rd: !w, dev: dev, addr: a, data: d};
    @(posedge ref_clk_i);
    req_i <= '0;
    ok = 1'b0;
    q = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (rd_valid_o === 1'b1);
      q = rd_data_o;
      if (!ok) @(posedge ref_clk_i);
    end
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic       ok;
    logic [7:0] q;
    acc(1'b1, dev_addr_i, a, d, ok, q);
    regs[a] = d;
  endtask : wr

  task automatic rd(input string what, input logic [2:0] dev, input logic [7:0] a, input logic valid);
    logic       ok;
    logic [7:0] q;
    acc(1'b0, dev, a, 8'h00, ok, q);
    chk({what, " valid"}, 16'(ok), 16'(valid));
    if (valid) chk(what, 16'(q), 16'(regs[a]));
  endtask : rd

  task automatic pwm_frame(input bit look);
    for (int t = 0; t < 160; t++) begin
      @(posedge ref_clk_i);
      pwm_in_i <= (t < 80);
      if (look && (t == 45 || t == 125)) begin
        #1;
        chk("spread", string_drive_o, spread_exp(t));
      end
    end
  endtask : pwm_frame

  initial begin
    #(100 * 20000);
    err_count++;
    end_sim();
  end

  initial begin
    logic [7:0] v;
    void'($urandom(32'h4758));
    init_model();
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    cyc(1);
    chk("drive in boot", string_drive_o, 16'h0000);
    cyc(170);
    chk("level after boot", 16'(string_current_level_o), 16'h005A);
    rd("pwm ctrl", dev_addr_i, 8'h2D, 1'b1);
    v = 8'($urandom());
    wr(8'h31, v);
    cyc(2);
    chk("level", 16'(string_current_level_o), 16'(v));
    rd("level reg", dev_addr_i, 8'h31, 1'b1);
    rd("other device", dev_addr_i + 3'h1, 8'h31, 1'b0);
    rd("unmapped", dev_addr_i, 8'hA5, 1'b1);
    wr(8'h2E, 8'h00);
    wr(8'h2D, 8'h03);
    @(posedge ref_clk_i) pwm_in_i <= 1'b1;
    cyc(3);
    // reference and count clock keep toggling meanwhile
    for (int i = 0; i < 20; i++) begin
      chk("direct high", string_drive_o, 16'hFFFF);
      cyc(1);
    end
    @(posedge ref_clk_i) pwm_in_i <= 1'b0;
    cyc(3);
    chk("direct low", string_drive_o, 16'h0000);
    wr(8'h2E, 8'h01);
    repeat (4) pwm_frame(1'b0);
    pwm_frame(1'b1);
    @(posedge ref_clk_i) fault_evt_i <= 40'h1;
    @(posedge ref_clk_i) fault_evt_i <= 40'h0;
    regs[8'h06] = 1;
    rd("fault set", dev_addr_i, 8'h06, 1'b1);
    wr(8'h12, 8'h01);
    cyc(1500);
    chk("optimizer on", 16'(optimizer_on_o), 16'h0001);
    chk("optimizer first step", optimizer_current_out_o[15:0], 16'h0101);
    @(posedge ref_clk_i) string_in_reg_i <= 16'hFFFE;
    cyc(1000);
    chk("optimizer back off", optimizer_current_out_o[15:0], 16'h0200);
    regs[8'h14] = 2;
    rd("optimizer readback", dev_addr_i, 8'h14, 1'b1);
    @(posedge ref_clk_i) enable_i <= 1'b0;
    pwm_in_i <= 1'b1;
    cyc(3);
    chk("drive off", string_drive_o, 16'h0000);
    chk("optimizer off", 16'(optimizer_on_o), 16'h0000);
    rd("disabled", dev_addr_i, 8'h31, 1'b0);
    @(posedge ref_clk_i) enable_i <= 1'b1;
    cyc(170);
    init_model();
    rd("fault clear", dev_addr_i, 8'h06, 1'b1);
    rd("reload", dev_addr_i, 8'h31, 1'b1);
    chk("level reload", 16'(string_current_level_o), 16'h005A);
    end_sim();
  end
endmodule : lsp_core_tb_top
`default_nettype wire
